// ==== inc/sac_pkg.sv ====
/*
 * Shared constants and types of the serial converter sequencer: register map,
 * command word layout, length codes, timing counts.
 * Assumes a 100 MHz aclk and a 32-bit AXI4-Lite register bus.
 */
package sac_pkg;

	// ---------------------------------------------------------------
	// Clock and timing
	// ---------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int CONV_TIME_NS = 10000;
	localparam int CONV_CYCLES = CONV_TIME_NS / CLK_PERIOD_NS;
	localparam int ABORT_TIME_NS = 5000;
	localparam int ABORT_CYCLES = ABORT_TIME_NS / CLK_PERIOD_NS;
	localparam int CS_SETUP_NS = 250;
	localparam int CS_SETUP_CYCLES = (CS_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ---------------------------------------------------------------
	// Register map
	// ---------------------------------------------------------------
	localparam logic [7:0] REG_CHAN_BASE = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h40;
	localparam int NUM_CHAN = 11;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Status register bit positions
	localparam int ST_EOC = 0;
	localparam int ST_BUSY = 1;
	localparam int ST_SAMPLING = 2;
	localparam int ST_POWER_DOWN = 3;
	localparam int ST_CMD_LSB = 8;

	// ---------------------------------------------------------------
	// Command word
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [3:0] addr;
		logic length_select_hi;
		logic length_select_lo;
		logic low_bit_first_select;
		logic signed_output_select;
	} sac_cmd_s;

	localparam sac_cmd_s CMD_RESET = 8'h00;
	localparam logic [3:0] ADDR_LAST_CHAN = 4'ha;
	localparam logic [3:0] ADDR_TEST_MID = 4'hb;
	localparam logic [3:0] ADDR_TEST_LOW = 4'hc;
	localparam logic [3:0] ADDR_TEST_HIGH = 4'hd;
	localparam logic [3:0] ADDR_POWER_DOWN = 4'he;
	localparam logic [11:0] CODE_TEST_MID = 12'h800;
	localparam logic [11:0] CODE_TEST_LOW = 12'h000;
	localparam logic [11:0] CODE_TEST_HIGH = 12'hfff;

	localparam logic [1:0] LEN_CODE_8 = 2'h1;
	localparam logic [1:0] LEN_CODE_16 = 2'h3;
	localparam logic [4:0] CLKS_8 = 5'h08;
	localparam logic [4:0] CLKS_12 = 5'h0c;
	localparam logic [4:0] CLKS_16 = 5'h10;
	localparam logic [3:0] CMD_BITS = 4'h8;
	localparam logic [3:0] LEN_BITS_SEEN = 4'h6;
	localparam logic [4:0] SAMPLE_START_FALL = 5'h04;

endpackage : sac_pkg

// ==== logic/sac_seq.sv ====
/*
 * Serial control and conversion sequencer of a 12-bit converter, with the
 * analog inputs modelled by software-written channel codes over AXI4-Lite.
 * Assumes select, shift clock and command line come from another clock
 * domain and are resynchronised here; the result line is split into
 * data, output enable (low = driving) for the bench to resolve.
 */
// Decided for this implementation: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/10ps

module sac_seq (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic select_n,
	input wire logic shift_clk,
	input wire logic cmd_in,
	output logic result_out,
	output logic result_oe_n,
	output logic eoc
);

	// ---------------------------------------------------------------
	// Pin synchronisers and edge detection
	// ---------------------------------------------------------------
	logic [2:0] sel_sync;
	logic [2:0] clk_sync;
	logic [1:0] din_sync;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sel_sync <= 3'h7;
			clk_sync <= 3'h0;
			din_sync <= 2'h0;
		end else begin
			sel_sync <= {sel_sync[1:0], select_n};
			clk_sync <= {clk_sync[1:0], shift_clk};
			din_sync <= {din_sync[0], cmd_in};
		end
	end

	wire sel_hi = sel_sync[1];
	wire sel_fall = !sel_sync[1] && sel_sync[2];
	wire sel_rise = sel_sync[1] && !sel_sync[2];
	wire io_rise = clk_sync[1] && !clk_sync[2];
	wire io_fall = !clk_sync[1] && clk_sync[2];
	wire din = din_sync[1];

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	logic [7:0] setup_cnt;
	logic [3:0] rise_cnt;
	logic [4:0] fall_cnt;
	logic [7:0] cmd_shift;
	sac_pkg::sac_cmd_s cmd;
	logic busy;
	logic sampling;
	logic power_down;
	logic [9:0] conv_cnt;
	logic [11:0] held;
	logic [15:0] out_word;
	logic [4:0] out_len;
	logic out_low_bit_first_select;
	logic [4:0] out_idx;
	logic [11:0] chan_val [sac_pkg::NUM_CHAN];

	// ---------------------------------------------------------------
	// Decode of the running cycle
	// ---------------------------------------------------------------
	wire setup_done = setup_cnt >= 8'(sac_pkg::CS_SETUP_CYCLES);
	wire active = !sel_hi && setup_done && !busy;
	wire take_bit = active && io_rise && rise_cnt < sac_pkg::CMD_BITS;
	// Length bits take effect in the cycle that carries them
	wire [1:0] len_code = (rise_cnt == sac_pkg::CMD_BITS) ? cmd_shift[3:2] :
		(rise_cnt == sac_pkg::CMD_BITS - 4'h1) ? cmd_shift[2:1] :
		(rise_cnt >= sac_pkg::LEN_BITS_SEEN) ? cmd_shift[1:0] :
		{cmd.length_select_hi, cmd.length_select_lo};
	wire [4:0] n_clks = (len_code == sac_pkg::LEN_CODE_8) ? sac_pkg::CLKS_8 :
		(len_code == sac_pkg::LEN_CODE_16) ? sac_pkg::CLKS_16 : sac_pkg::CLKS_12;
	wire [4:0] fall_next = fall_cnt + 5'h01;
	wire last_fall = active && io_fall && fall_next == n_clks;
	wire sample_start = active && io_fall && fall_next == sac_pkg::SAMPLE_START_FALL;
	wire sac_pkg::sac_cmd_s new_cmd = cmd_shift;
	wire go_power_down = new_cmd.addr == sac_pkg::ADDR_POWER_DOWN;
	wire conv_done = busy && conv_cnt == 10'(sac_pkg::CONV_CYCLES - 1);
	wire abort = busy && sel_fall && conv_cnt < 10'(sac_pkg::ABORT_CYCLES);

	// Input selected by the command that ends this cycle
	wire [11:0] sel_val = (new_cmd.addr <= sac_pkg::ADDR_LAST_CHAN) ? chan_val[new_cmd.addr] :
		(new_cmd.addr == sac_pkg::ADDR_TEST_MID) ? sac_pkg::CODE_TEST_MID :
		(new_cmd.addr == sac_pkg::ADDR_TEST_LOW) ? sac_pkg::CODE_TEST_LOW :
		sac_pkg::CODE_TEST_HIGH;

	// Left-justified frame serves all lengths: 16 pads, 8 drops low bits
	wire [11:0] coded = cmd.signed_output_select ? {~held[11], held[10:0]} : held;
	wire [15:0] frame = {coded, 4'h0};
	wire [4:0] out_pos = out_low_bit_first_select ? out_len - 5'h01 - out_idx : out_idx;
	wire [3:0] out_bit_sel = 4'hf - out_pos[3:0];

	// ---------------------------------------------------------------
	// I/O cycle
	// ---------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			setup_cnt <= 8'h00;
			rise_cnt <= 4'h0;
			fall_cnt <= 5'h00;
			cmd_shift <= 8'h00;
			sampling <= 1'b0;
		end else if (sel_hi || sel_fall) begin
			setup_cnt <= 8'h00;
			rise_cnt <= 4'h0;
			fall_cnt <= 5'h00;
			sampling <= 1'b0;
		end else begin
			if (!setup_done) begin
				setup_cnt <= setup_cnt + 8'h01;
			end
			if (take_bit) begin
				cmd_shift <= {cmd_shift[6:0], din};
				rise_cnt <= rise_cnt + 4'h1;
			end
			if (last_fall) begin
				fall_cnt <= 5'h00;
				rise_cnt <= 4'h0;
				sampling <= 1'b0;
			end else if (active && io_fall) begin
				fall_cnt <= fall_next;
				if (sample_start) begin
					sampling <= 1'b1;
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// Conversion
	// ---------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cmd <= sac_pkg::CMD_RESET;
			eoc <= 1'b1;
			busy <= 1'b0;
			power_down <= 1'b0;
			conv_cnt <= 10'h000;
			held <= 12'h000;
		end else if (last_fall) begin
			cmd <= new_cmd;
			power_down <= go_power_down;
			held <= sel_val;
			busy <= !go_power_down;
			eoc <= go_power_down;
			conv_cnt <= 10'h000;
		end else if (abort || conv_done) begin
			busy <= 1'b0;
			eoc <= 1'b1;
		end else if (busy) begin
			conv_cnt <= conv_cnt + 10'h001;
		end
	end

	// ---------------------------------------------------------------
	// Output register and result line
	// ---------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			out_word <= 16'h0000;
			out_len <= sac_pkg::CLKS_12;
			out_low_bit_first_select <= 1'b0;
			out_idx <= 5'h00;
		end else if (conv_done) begin
			out_word <= frame;
			out_len <= n_clks;
			out_low_bit_first_select <= cmd.low_bit_first_select;
			out_idx <= 5'h00;
		end else if (sel_fall) begin
			out_idx <= 5'h00;
		end else if (active && io_fall && out_idx < 5'h0f) begin
			out_idx <= out_idx + 5'h01;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			result_out <= 1'b0;
			result_oe_n <= 1'b1;
		end else begin
			result_out <= out_word[out_bit_sel];
			result_oe_n <= sel_hi;
		end
	end

	// ---------------------------------------------------------------
	// AXI4-Lite register slave
	// ---------------------------------------------------------------
	logic aw_full;
	logic w_full;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;

	wire [3:0] wr_idx = aw_addr[5:2];
	wire wr_hit = aw_addr[7:6] == 2'h0 && aw_addr[1:0] == 2'h0 && wr_idx <= sac_pkg::ADDR_LAST_CHAN;
	wire wr_go = aw_full && w_full && !bvalid;
	wire [3:0] rd_idx = araddr[5:2];
	wire rd_chan = araddr[7:6] == 2'h0 && araddr[1:0] == 2'h0 && rd_idx <= sac_pkg::ADDR_LAST_CHAN;
	wire rd_stat = araddr == sac_pkg::REG_STATUS;
	wire [31:0] status = (32'(cmd) << sac_pkg::ST_CMD_LSB) |
		(32'(power_down) << sac_pkg::ST_POWER_DOWN) | (32'(sampling) << sac_pkg::ST_SAMPLING) |
		(32'(busy) << sac_pkg::ST_BUSY) | (32'(eoc) << sac_pkg::ST_EOC);

	assign awready = !aw_full;
	assign wready = !w_full;
	assign arready = !rvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full <= 1'b0;
			w_full <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			bvalid <= 1'b0;
			bresp <= sac_pkg::RESP_OKAY;
		end else begin
			if (awvalid && awready) begin
				aw_full <= 1'b1;
				aw_addr <= awaddr;
			end
			if (wvalid && wready) begin
				w_full <= 1'b1;
				w_data <= wdata;
				w_strb <= wstrb;
			end
			if (wr_go) begin
				aw_full <= 1'b0;
				w_full <= 1'b0;
				bvalid <= 1'b1;
				bresp <= wr_hit ? sac_pkg::RESP_OKAY : sac_pkg::RESP_SLVERR;
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (wr_go && wr_hit) begin
			if (w_strb[0]) begin
				chan_val[wr_idx][7:0] <= w_data[7:0];
			end
			if (w_strb[1]) begin
				chan_val[wr_idx][11:8] <= w_data[11:8];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= sac_pkg::RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid <= 1'b1;
			rdata <= rd_chan ? {20'h00000, chan_val[rd_idx]} : rd_stat ? status : 32'h0000_0000;
			rresp <= (rd_chan || rd_stat) ? sac_pkg::RESP_OKAY : sac_pkg::RESP_SLVERR;
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	property p_float_when_high;
		@(posedge aclk) disable iff (!aresetn) sel_hi |=> result_oe_n;
	endproperty
	a_float_when_high: assert property (p_float_when_high) else $error("result line driven");

	property p_drive_when_low;
		@(posedge aclk) disable iff (!aresetn) !sel_hi |=> !result_oe_n;
	endproperty
	a_drive_when_low: assert property (p_drive_when_low) else $error("result line not driven");

	property p_cmd_frozen;
		@(posedge aclk) disable iff (!aresetn)
			(rise_cnt == sac_pkg::CMD_BITS && io_rise && !sel_hi) |=> $stable(cmd_shift);
	endproperty
	a_cmd_frozen: assert property (p_cmd_frozen) else $error("command taken past eighth");

	property p_cycle_len;
		@(posedge aclk) disable iff (!aresetn)
			last_fall |-> fall_cnt == n_clks - 5'h01 && rise_cnt == sac_pkg::CMD_BITS;
	endproperty
	a_cycle_len: assert property (p_cycle_len) else $error("wrong cycle length");

	property p_eoc_low;
		@(posedge aclk) disable iff (!aresetn)
			(last_fall && !go_power_down) |=> !eoc && busy ##1 !eoc[*8];
	endproperty
	a_eoc_low: assert property (p_eoc_low) else $error("flag not low at cycle end");

	property p_eoc_after_latch;
		@(posedge aclk) disable iff (!aresetn) $rose(eoc) |-> $past(busy) && out_idx == 5'h00;
	endproperty
	a_eoc_after_latch: assert property (p_eoc_after_latch) else $error("flag rose early");

	property p_start_after_cycle;
		@(posedge aclk) disable iff (!aresetn) $rose(busy) |-> $past(last_fall);
	endproperty
	a_start_after_cycle: assert property (p_start_after_cycle) else $error("early conversion");

	property p_partial_dropped;
		@(posedge aclk) disable iff (!aresetn) sel_rise |=> fall_cnt == 5'h00 && rise_cnt == 4'h0;
	endproperty
	a_partial_dropped: assert property (p_partial_dropped) else $error("partial cycle kept");

	property p_setup_ignore;
		@(posedge aclk) disable iff (!aresetn) sel_fall |=> !active[*8];
	endproperty
	a_setup_ignore: assert property (p_setup_ignore) else $error("inputs taken in setup");

endmodule : sac_seq

// ==== tb/sac_host.sv ====
/*
 * Host serial port model: drives select, shift clock and command line.
 * Assumes the design's result line is split into data and enable (low = driving).
 */
`timescale 1ns/10ps
module sac_host (
	input wire logic aclk,
	input wire logic result_out,
	input wire logic result_oe_n,
	output logic select_n,
	output logic shift_clk,
	output logic cmd_in
);
	logic fill = 1'b0;
	logic line;
	// Released wire shows a pattern that changes every cycle
	assign line = result_oe_n ? fill : result_out;
	always @(posedge aclk) begin
		fill <= ~fill;
	end
	initial begin
		select_n = 1'b1;
		shift_clk = 1'b0;
		cmd_in = 1'b0;
	end
	task frame(input logic [7:0] cmd, input int n, input bit raise, output logic [15:0] rd);
		rd = 16'h0000;
		select_n <= 1'b0;
		#400;
		for (int i = 0; i < n; i++) begin
			cmd_in <= (i < 8) ? cmd[7 - i] : ~cmd_in;
			#62.5 shift_clk <= 1'b1;
			rd[15 - i] = line;
			#62.5 shift_clk <= 1'b0;
		end
		#100 select_n <= raise ? 1'b1 : 1'b0;
	endtask : frame
	task idle(input int k);
		for (int i = 0; i < k; i++) begin
			#62.5 shift_clk <= 1'b1;
			#62.5 shift_clk <= 1'b0;
		end
	endtask : idle
	task reselect();
		select_n <= 1'b1;
		#400 select_n <= 1'b0;
		#400;
	endtask : reselect
endmodule : sac_host

// ==== tb/tb.sv ====
/*
 * Self-checking bench of the converter sequencer: AXI4-Lite register access and
 * serial frames through the host model. Assumes a 100 MHz aclk.
 */
`timescale 1ns/10ps
module tb;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'h0;
	logic awready, wready, bvalid, arready, rvalid, result_out, result_oe_n, eoc;
	logic select_n, shift_clk, cmd_in;
	logic [1:0] bresp, rresp, rr;
	logic [31:0] rdata, rv;
	int num_errors = 0, n_compared = 0, cycles = 0;
	logic [31:0] seed = 32'ha2907819;
	logic [11:0] codes [0:13];
	logic [7:0] pcmd = 8'h00, c;
	logic [11:0] pcode = 12'h000;
	logic [15:0] rd;

	sac_seq dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.select_n(select_n), .shift_clk(shift_clk), .cmd_in(cmd_in),
		.result_out(result_out), .result_oe_n(result_oe_n), .eoc(eoc));
	sac_host u_host (.aclk(aclk), .result_out(result_out), .result_oe_n(result_oe_n),
		.select_n(select_n), .shift_clk(shift_clk), .cmd_in(cmd_in));

	always #5 aclk = ~aclk;
	always @(posedge aclk) begin
		cycles++;
		if (cycles == 80000) begin
			num_errors++;
			finish_test();
		end
	end

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	function automatic int nclk(input logic [7:0] k);
		case (k[3:2])
			2'h1: return 8;
			2'h3: return 16;
			default: return 12;
		endcase
	endfunction : nclk
	function automatic logic [15:0] fexp(input logic [7:0] k, input logic [11:0] code);
		logic [15:0] v, b;
		int n;
		v = {code ^ {k[0], 11'h000}, 4'h0};
		n = nclk(k);
		b = 16'h0000;
		for (int i = 0; i < n; i++) b[15 - i] = k[1] ? v[16 - n + i] : v[15 - i];
		return b;
	endfunction : fexp
	task chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	task axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		bit aw_d, w_d;
		@(posedge aclk);
		{aw_d, w_d} = 2'b00;
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw_d && w_d)) begin
			@(negedge aclk);
			if (awready === 1'b1) aw_d = 1'b1;
			if (wready === 1'b1) w_d = 1'b1;
			@(posedge aclk);
			if (aw_d) awvalid <= 1'b0;
			if (w_d) wvalid <= 1'b0;
		end
		while (bvalid !== 1'b1) @(negedge aclk);
		chk(bresp, er);
		@(posedge aclk);
		bready <= 1'b0;
	endtask : axi_wr
	task axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (arready !== 1'b1) @(negedge aclk);
		@(posedge aclk);
		arvalid <= 1'b0;
		while (rvalid !== 1'b1) @(negedge aclk);
		d = rdata;
		r = rresp;
		@(posedge aclk);
		rready <= 1'b0;
	endtask : axi_rd
	task do_frame(input logic [7:0] k, input bit raise, input bit cmp);
		int cnt;
		u_host.frame(k, nclk(k), raise, rd);
		if (cmp) chk(rd & (16'hffff << (16 - nclk(pcmd))), fexp(pcmd, pcode));
		if (k[7:4] == 4'he) begin
			repeat (60) @(negedge aclk);
			chk(eoc, 1);
		end else begin
			for (cnt = 0; cnt < 30 && eoc !== 1'b0; cnt++) @(negedge aclk);
			chk(eoc, 0);
			for (cnt = 0; cnt < 1200 && eoc !== 1'b1; cnt++) @(negedge aclk);
			chk(cnt > 975 && cnt < 1010, 1);
			pcmd = k;
			pcode = codes[k[7:4]];
		end
	endtask : do_frame
	task finish_test();
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : finish_test

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		@(negedge aclk);
		chk(eoc, 1);
		chk(result_oe_n, 1);
		axi_rd(8'h40, rv, rr);
		chk(rv[15:8], 0);
		for (int i = 0; i < 11; i++) begin
			rv = rnd();
			codes[i] = rv[11:0];
			axi_wr(8'(i * 4), {20'h0, codes[i]}, 2'h0);
		end
		codes[11] = 12'h800;
		codes[12] = 12'h000;
		codes[13] = 12'hfff;
		axi_rd(8'h14, rv, rr);
		chk(rv[11:0], codes[5]);
		axi_wr(8'h80, 32'h1, 2'h2);
		axi_wr(8'h40, 32'h1, 2'h2);
		axi_rd(8'h80, rv, rr);
		chk(rr, 2);
		$display("test registers done");
		u_host.idle(6);
		repeat (20) @(negedge aclk);
		chk(result_oe_n, 1);
		chk(eoc, 1);
		do_frame(8'h00, 1, 0);
		for (int g = 0; g < 4; g++) begin
			for (int k = 0; k < 4; k++) begin
				rv = rnd();
				c = {4'(rv[7:4] % 4'he), g[1:0], rv[1:0]};
				do_frame(c, rv[8], k > 0);
			end
		end
		$display("test lengths done");
		u_host.frame(8'h00, 5, 1, rd);
		repeat (100) @(negedge aclk);
		chk(eoc, 1);
		do_frame({pcmd[7:4] ^ 4'h1, pcmd[3:0]}, 1, 1);
		c = {pcmd[7:4] ^ 4'h1, pcmd[3:0]};
		u_host.frame(c, nclk(c), 1, rd);
		repeat (100) @(negedge aclk);
		u_host.reselect();
		chk(eoc, 1);
		do_frame(c, 1, 1);
		do_frame({4'he, pcmd[3:0]}, 1, 1);
		do_frame(pcmd, 1, 0);
		$display("test control done");
		finish_test();
	end
endmodule : tb
